// file: inc/sub_exec_pkg.sv
// Constants for the subtract execution unit
// Assumes an 8-bit core datapath and a 12-bit data address space
package sub_exec_pkg;
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 12;
  localparam int          BANK_W         = 4;
  // Indexed literal offset applies to access-bank addresses up to this value
  localparam logic [7:0]  IDX_LIMIT      = 8'h5F;
  // Access-bank addresses from this value up map onto the special function register page
  localparam logic [7:0]  ACC_SPLIT      = 8'h60;
  localparam logic [3:0]  SFR_BANK       = 4'hF;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam int          STATUS_N       = 4;
  localparam int          STATUS_OV      = 3;
  localparam int          STATUS_Z       = 2;
  localparam int          STATUS_DC      = 1;
  localparam int          STATUS_C       = 0;
  localparam logic [4:0]  RST_STATUS     = 5'h00;
  localparam logic [11:0] RST_ADDR       = 12'h000;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_SUB_FILE_FROM_WORK_BORROW,
    OP_SUB_WORK_FROM_LITERAL
  } sub_op_t;
endpackage : sub_exec_pkg

// file: rtl/sub_exec.sv
// Execution unit for the two subtract instructions of the core
// Assumes the decoder presents one instruction per cycle, a file read port
// with combinational data, and that it commits the registered results.
//
// Function
// [RULE1] W minus file minus inverted carry
// [RULE2] Destination bit picks W or file
// [RULE3] Access bit picks access bank or bank_select_reg
// [RULE4] Extended set, a=0, low f: indexed
// [RULE5] Literal minus W, result to W
// [RULE6] Update N, overflow, C, digit carry, Z
`timescale 1ns/1ps
module sub_exec
  import sub_exec_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_resetn,
  input  wire sub_op_t           i_op,
  input  wire logic [7:0]        i_operand,
  input  wire logic              i_dest,
  input  wire logic              i_access,
  input  wire logic              i_ext_set_en,
  input  wire logic [BANK_W-1:0] i_bank_select_reg,
  input  wire logic [ADDR_W-1:0] i_index_ptr,
  input  wire logic [7:0]        i_work_reg,
  input  wire logic [4:0]        i_status,
  input  wire logic [7:0]        i_file_rdata,
  output logic      [ADDR_W-1:0] o_file_addr,
  output logic      [7:0]        o_file_wdata,
  output logic                   o_file_we,
  output logic      [7:0]        o_work_wdata,
  output logic                   o_work_we,
  output logic      [4:0]        o_status,
  output logic                   o_status_we
);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        fwdata;
    logic              fwe;
    logic [7:0]        wwdata;
    logic              wwe;
    logic [4:0]        status;
    logic              swe;
  } state_t;

  state_t     st_ff;
  state_t     nxt_st;
  logic [ADDR_W-1:0] rd_addr;

  // ************************************************************
  // Operand address
  // ************************************************************
  // Read address is formed combinationally but reaches o_file_addr through the register, one cycle later
  always_comb begin
    if (!i_access) begin
      if (i_ext_set_en && (i_operand <= IDX_LIMIT)) begin
        rd_addr = i_index_ptr + {{(ADDR_W-8){1'b0}}, i_operand};     // [RULE4]
      end else if (i_operand >= ACC_SPLIT) begin
        rd_addr = {SFR_BANK, i_operand};                              // [RULE3]
      end else begin
        rd_addr = {4'h0, i_operand};                                  // [RULE3]
      end
    end else begin
      rd_addr = {i_bank_select_reg, i_operand};                       // [RULE3]
    end
  end

  // ************************************************************
  // Arithmetic
  // ************************************************************
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic       borrow_in;
  logic [8:0] diff;
  logic [4:0] lo_diff;
  logic [7:0] result;

  always_comb begin
    if (i_op == OP_SUB_WORK_FROM_LITERAL) begin
      minuend    = i_operand;                                         // [RULE5]
      subtrahend = i_work_reg;
      borrow_in  = 1'b0;
    end else begin
      minuend    = i_work_reg;                                        // [RULE1]
      subtrahend = i_file_rdata;
      borrow_in  = ~i_status[STATUS_C];
    end
    // Carry out of 9-bit add of the complement means no borrow
    diff    = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, ~borrow_in};
    lo_diff = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, ~borrow_in};
    result  = diff[7:0];
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.fwe    = 1'b0;
    nxt_st.wwe    = 1'b0;
    nxt_st.swe    = 1'b0;
    nxt_st.addr   = rd_addr;
    unique case (i_op)
      OP_SUB_FILE_FROM_WORK_BORROW: begin
        nxt_st.fwdata = result;
        nxt_st.wwdata = result;
        nxt_st.fwe    = i_dest;                                       // [RULE2]
        nxt_st.wwe    = ~i_dest;                                      // [RULE2]
        nxt_st.swe    = 1'b1;
      end
      OP_SUB_WORK_FROM_LITERAL: begin
        nxt_st.wwdata = result;                                       // [RULE5]
        nxt_st.wwe    = 1'b1;
        nxt_st.swe    = 1'b1;
      end
      OP_NONE: begin
      end
      default: begin
      end
    endcase
    if (i_op != OP_NONE) begin
      nxt_st.status[STATUS_C]  = diff[8];                             // [RULE6]
      nxt_st.status[STATUS_DC] = lo_diff[4];                          // [RULE6]
      nxt_st.status[STATUS_Z]  = (result == 8'h00);                   // [RULE6]
      nxt_st.status[STATUS_N]  = result[7];                           // [RULE6]
      nxt_st.status[STATUS_OV] = (minuend[7] ^ subtrahend[7]) &
                                 (minuend[7] ^ result[7]);            // [RULE6]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= '{addr: RST_ADDR, fwdata: RST_BYTE, fwe: 1'b0, wwdata: RST_BYTE,
                 wwe: 1'b0, status: RST_STATUS, swe: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_file_addr  = st_ff.addr;
  assign o_file_wdata = st_ff.fwdata;
  assign o_file_we    = st_ff.fwe;
  assign o_work_wdata = st_ff.wwdata;
  assign o_work_we    = st_ff.wwe;
  assign o_status     = st_ff.status;
  assign o_status_we  = st_ff.swe;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  borrow_result_a: assert property ((i_op == OP_SUB_FILE_FROM_WORK_BORROW) |=>  // [RULE1]
    o_status_we && (o_work_we ? o_work_wdata : o_file_wdata) ==
    8'($past(i_work_reg) - $past(i_file_rdata) - {7'h00, ~$past(i_status[STATUS_C])}))
    else $error("borrow subtract result wrong");
  dest_select_a: assert property ((i_op == OP_SUB_FILE_FROM_WORK_BORROW) |=>  // [RULE2]
    (o_file_we == $past(i_dest)) && (o_work_we != $past(i_dest)))
    else $error("destination select wrong");
  bank_addr_a: assert property ((i_op != OP_NONE) && i_access |=>  // [RULE3]
    o_file_addr == {$past(i_bank_select_reg), $past(i_operand)})
    else $error("banked address wrong");
  indexed_addr_a: assert property ((i_op != OP_NONE) && !i_access && i_ext_set_en &&  // [RULE4]
    (i_operand <= IDX_LIMIT) |=> o_file_addr == 12'($past(i_index_ptr) + {4'h0, $past(i_operand)}))
    else $error("indexed address wrong");
  literal_work_a: assert property ((i_op == OP_SUB_WORK_FROM_LITERAL) |=>  // [RULE5]
    o_work_we && !o_file_we && o_work_wdata == 8'($past(i_operand) - $past(i_work_reg)))
    else $error("literal subtract wrong");
  zero_flag_a: assert property (o_status_we |->  // [RULE6]
    o_status[STATUS_Z] == (o_work_we ? o_work_wdata == 8'h00 : o_file_wdata == 8'h00))
    else $error("zero flag wrong");
  carry_flag_a: assert property ((i_op == OP_SUB_WORK_FROM_LITERAL) |=>  // [RULE6]
    o_status[STATUS_C] == ($past(i_operand) >= $past(i_work_reg)))
    else $error("carry flag wrong");
  idle_quiet_a: assert property ((i_op == OP_NONE) |=> !o_work_we && !o_file_we && !o_status_we)  // [RULE2]
    else $error("write without instruction");

  // ************************************************************
  // Flag and address checks
  // ************************************************************
  // C and DC rebuilt from sampled operands, so a datapath slip shows; OV and N are checked against the written result
  sequence borrow_op_s;
    i_op == OP_SUB_FILE_FROM_WORK_BORROW;
  endsequence

  sequence literal_op_s;
    i_op == OP_SUB_WORK_FROM_LITERAL;
  endsequence

  sequence access_low_s;
    (i_op != OP_NONE) && !i_access && !(i_ext_set_en && (i_operand <= IDX_LIMIT)) &&
    (i_operand < ACC_SPLIT);
  endsequence

  sequence access_sfr_s;
    (i_op != OP_NONE) && !i_access && (i_operand >= ACC_SPLIT);
  endsequence

  access_low_a: assert property (access_low_s |=>  // [RULE3]
    o_file_addr == {4'h0, $past(i_operand)})
    else $error("access bank low address wrong");
  access_sfr_a: assert property (access_sfr_s |=>  // [RULE3]
    o_file_addr == {SFR_BANK, $past(i_operand)})
    else $error("access bank upper address wrong");
  borrow_carry_a: assert property (borrow_op_s |=>  // [RULE6]
    o_status[STATUS_C] == ({1'b0, $past(i_work_reg)} >=
                           ({1'b0, $past(i_file_rdata)} + {8'h00, ~$past(i_status[STATUS_C])})))
    else $error("borrow carry flag wrong");
  literal_dc_a: assert property (literal_op_s |=>  // [RULE6]
    o_status[STATUS_DC] == ($past(i_operand[3:0]) >= $past(i_work_reg[3:0])))
    else $error("literal digit carry wrong");
  literal_ov_a: assert property (literal_op_s |=>  // [RULE6]
    o_status[STATUS_OV] == (($past(i_operand[7]) != $past(i_work_reg[7])) &&
                            (o_work_wdata[7] != $past(i_operand[7]))))
    else $error("literal overflow flag wrong");
  negative_flag_a: assert property (o_status_we |->  // [RULE6]
    o_status[STATUS_N] == (o_work_we ? o_work_wdata[7] : o_file_wdata[7]))
    else $error("negative flag wrong");
  idle_hold_a: assert property ((i_op == OP_NONE) |=> $stable(o_status))  // [RULE6]
    else $error("flags moved without instruction");

endmodule : sub_exec

// file: sim/sub_exec_tb.sv
// Self-checking bench for the subtract execution unit
// Assumes one instruction per cycle and registered results one cycle later
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sub_exec_tb;
  import sub_exec_pkg::*;
  logic              i_sys_clk = 1'b0, i_resetn = 1'b0;
  sub_op_t           i_op = OP_NONE, e_op = OP_NONE;
  logic [7:0]        i_operand = 8'h00, i_work_reg = 8'h00, i_file_rdata = 8'h00, e_res;
  logic              i_dest = 1'b0, i_access = 1'b0, i_ext_set_en = 1'b0, e_d, wf;
  logic [3:0]        i_bank_select_reg = 4'h0;
  logic [11:0]       i_index_ptr = 12'h000, o_file_addr, e_addr;
  logic [4:0]        i_status = 5'h00, o_status, e_st;
  logic [7:0]        o_file_wdata, o_work_wdata;
  logic              o_file_we, o_work_we, o_status_we;
  int                miscompares = 0, checks = 0, cycles = 0;
  integer            seed = 32'h6e8f;
  logic [31:0]       r;
  sub_exec uut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_op(i_op), .i_operand(i_operand),
    .i_dest(i_dest), .i_access(i_access), .i_ext_set_en(i_ext_set_en), .i_bank_select_reg(i_bank_select_reg),
    .i_index_ptr(i_index_ptr), .i_work_reg(i_work_reg), .i_status(i_status), .i_file_rdata(i_file_rdata),
    .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata), .o_file_we(o_file_we),
    .o_work_wdata(o_work_wdata), .o_work_we(o_work_we), .o_status(o_status), .o_status_we(o_status_we));
  always #5 i_sys_clk = ~i_sys_clk;
  // ****************************************
  // Verdict and hang guard
  // ****************************************
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  // ****************************************
  // One instruction in, previous one checked
  // ****************************************
  // Checks land 1 ns after the edge, so back-to-back issue is exercised every cycle
  task automatic run_op(input sub_op_t op, input logic [7:0] opd, w, fd, input logic c, d, a, x);
    logic [8:0]  full;
    logic [4:0]  nib;
    logic [7:0]  m, s;
    logic [3:0]  bank_select_reg;
    logic [11:0] ptr;
    logic [4:0]  st;
    logic        bin;
    bank_select_reg = 4'($random(seed));
    ptr = 12'($random(seed));
    st = 5'($random(seed));
    st[STATUS_C] = c;
    @(posedge i_sys_clk);
    i_op <= op; i_operand <= opd; i_work_reg <= w; i_file_rdata <= fd; i_status <= st;
    i_dest <= d; i_access <= a; i_ext_set_en <= x; i_bank_select_reg <= bank_select_reg; i_index_ptr <= ptr;
    #1;
    if (e_op == OP_NONE) `CHK({o_file_we, o_work_we, o_status_we}, 3'b000)
    else begin
      wf = (e_op == OP_SUB_FILE_FROM_WORK_BORROW) && e_d;
      `CHK(o_file_we, wf)
      `CHK(o_work_we, !wf)
      `CHK(wf ? o_file_wdata : o_work_wdata, e_res)
      `CHK(o_status_we, 1'b1)
      `CHK(o_status, e_st)
      if (e_op == OP_SUB_FILE_FROM_WORK_BORROW) `CHK(o_file_addr, e_addr)
    end
    // Literal form never borrows in; file form borrows on a clear carry
    bin = (op == OP_SUB_WORK_FROM_LITERAL) ? 1'b0 : !c;
    m = (op == OP_SUB_WORK_FROM_LITERAL) ? opd : w;
    s = (op == OP_SUB_WORK_FROM_LITERAL) ? w : fd;
    full = {1'b0, m} - {1'b0, s} - 9'(bin);
    nib = {1'b0, m[3:0]} - {1'b0, s[3:0]} - 5'(bin);
    e_res = full[7:0];
    e_st = {e_res[7], (m[7] != s[7]) && (e_res[7] != m[7]), e_res == 8'h00, ~nib[4], ~full[8]};
    e_addr = a ? {bank_select_reg, opd} : (x && opd <= IDX_LIMIT) ? ptr + {4'h0, opd}
           : (opd >= ACC_SPLIT) ? {SFR_BANK, opd} : {4'h0, opd};
    e_op = op;
    e_d = d;
  endtask : run_op
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    run_op(OP_SUB_FILE_FROM_WORK_BORROW, 8'h10, 8'h02, 8'h03, 1'b1, 1'b1, 1'b0, 1'b0);
    run_op(OP_SUB_FILE_FROM_WORK_BORROW, 8'h10, 8'h05, 8'h02, 1'b1, 1'b0, 1'b0, 1'b0);
    run_op(OP_SUB_FILE_FROM_WORK_BORROW, 8'h10, 8'h02, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0);
    for (int w = 1; w < 4; w++) run_op(OP_SUB_WORK_FROM_LITERAL, 8'h02, 8'(w), 8'h55, 1'b0, 1'b1, 1'b1, 1'b0);
    // Edges of the indexed window and the access-bank split
    run_op(OP_SUB_FILE_FROM_WORK_BORROW, 8'h5F, 8'h80, 8'h01, 1'b1, 1'b1, 1'b0, 1'b1);
    run_op(OP_SUB_FILE_FROM_WORK_BORROW, 8'h60, 8'h7F, 8'hFF, 1'b1, 1'b1, 1'b0, 1'b1);
    run_op(OP_SUB_FILE_FROM_WORK_BORROW, 8'h5F, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    run_op(OP_SUB_FILE_FROM_WORK_BORROW, 8'h20, 8'h10, 8'h01, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (300) begin
      r = $random(seed);
      run_op((r[1:0] == 2'b11) ? OP_NONE : sub_op_t'(r[1:0]), r[9:2], r[17:10], r[25:18],
             r[26], r[27], r[28], r[29]);
    end
    run_op(OP_NONE, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    tally_and_finish;
  end
endmodule : sub_exec_tb
